// >>> pkg/cfm_pkg.sv
// Package of constants and types for the CAN bus failure manager
package cfm_pkg;
    // Avalon register word offsets (byte addresses)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
    localparam int ADDR_W = 4;
    // Control field positions
    localparam int CTRL_STB_N = 0;
    localparam int CTRL_ENT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // Interrupt event bit positions
    localparam int EV_FAIL = 0;
    localparam int EV_TXTO = 1;
    localparam int EV_OVT = 2;
    localparam int EV_WAKE = 3;
    localparam int EV_MODE = 4;
    localparam int EV_W = 5;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
    // Timing at 10 MHz: startup in microseconds, filter, recovery and timeout in clock cycles
    localparam int CLK_MHZ = 10;
    localparam int STARTUP_US = 10;
    localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
    localparam int FILTER_CYC = 40;
    localparam int RECOVER_CYC = 80;
    localparam int TXTO_CYC = 4000;
    localparam int CNT_W = 16;
    // Comparator vector: [0] H above batt, [1] H below gnd, [2] L above batt, [3] L below gnd
    localparam int CMP_W = 4;
    typedef enum logic [2:0] {
        CFM_OFF, CFM_STARTUP, CFM_NORMAL, CFM_VCC_STBY, CFM_VBAT_STBY, CFM_GOSLEEP, CFM_SLEEP
    } cfm_mode_t;
endpackage

// >>> rtl/cfm_fail_filter.sv
// Persistence filter: output follows input only after a held count
`timescale 1ns/1ps
`default_nettype none
module cfm_fail_filter #(
    parameter int SET_CYC = 40,
    parameter int CLR_CYC = 80,
    parameter int CNT_W = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_raw,
    output logic o_filt
);
    logic [CNT_W-1:0] cnt;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= '0;
            o_filt <= 1'b0;
        end else if (i_ce) begin
            if (i_raw == o_filt) begin
                cnt <= '0;
            end else if (!o_filt && cnt >= CNT_W'(SET_CYC - 1)) begin
                o_filt <= 1'b1;
                cnt <= '0;
            end else if (o_filt && cnt >= CNT_W'(CLR_CYC - 1)) begin
                o_filt <= 1'b0;
                cnt <= '0;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule // cfm_fail_filter
`default_nettype wire

// >>> rtl/cfm_core.sv
// Mode state machine, failure management and register slave of the CAN transceiver
`timescale 1ns/1ps
`default_nettype none
module cfm_core
    import cfm_pkg::*;
#(
    parameter int FILTER_CYCLES = cfm_pkg::FILTER_CYC,
    parameter int RECOVER_CYCLES = cfm_pkg::RECOVER_CYC,
    parameter int TXTO_CYCLES = cfm_pkg::TXTO_CYC,
    parameter int STARTUP_CYCLES = cfm_pkg::STARTUP_CYC,
    // Per comparator pattern: bit0 = single-wire case on H, bit1 = on L, bit2 = dominant-only case
    parameter logic [63:0] DECODE_TABLE = 64'h4441_1142_1210_1200
) (
    // Clock, reset, enable
    input wire logic I_MCLK,
    input wire logic I_RSTN,
    input wire logic I_CE,
    // Supplies and analog sensing
    input wire logic I_VCC_OK,
    input wire logic I_VBAT_OK,
    input wire logic I_OVERTEMP,
    input wire logic I_WAKE_PIN,
    input wire logic I_DIFF_DOM,
    input wire logic [cfm_pkg::CMP_W-1:0] I_LINE_CMP,
    input wire logic I_CANH_DOM,
    input wire logic I_CANL_DOM,
    // Controller side
    input wire logic I_TXD,
    output logic O_RXD,
    output logic O_BUS_ERROR_INDICATOR_N,
    // Bus side controls
    output logic O_CANH_DRV_EN,
    output logic O_CANL_DRV_EN,
    output logic O_CAN_TX_DOM,
    output logic O_HIGH_LINE_TERMINATION,
    output logic O_LOW_LINE_TERMINATION,
    output logic O_REGULATOR_INHIBIT_OUT,
    // Avalon-MM slave
    input wire logic [cfm_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    output logic O_IRQ
);
    import cfm_pkg::*;

    cfm_mode_t mode;
    cfm_mode_t next_mode;
    logic [1:0] ctrl;
    logic standby_select_n;
    logic transfer_enable_in;
    logic [CNT_W-1:0] su_cnt;
    logic [CNT_W-1:0] tx_cnt;
    logic tx_timeout;
    logic [2:0] dec;
    logic [1:0] sw_raw;
    logic [1:0] sw_filt;
    logic dom_fail;
    logic fail_latched;
    logic txd_q;
    logic wake_q;
    logic wake_req;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_mask;
    logic [EV_W-1:0] ev;
    logic ack;
    cfm_mode_t mode_q;

    assign standby_select_n = ctrl[CTRL_STB_N];
    assign transfer_enable_in = ctrl[CTRL_ENT];

    // Decode one table nibble per comparator pattern
    always_comb begin
        dec = DECODE_TABLE[{I_LINE_CMP, 2'b00} +: 3];
        sw_raw = dec[1:0];
        dom_fail = dec[2] && (I_DIFF_DOM || I_CANH_DOM || I_CANL_DOM);
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_line
            cfm_fail_filter #(
                .SET_CYC(FILTER_CYCLES),
                .CLR_CYC(RECOVER_CYCLES),
                .CNT_W(CNT_W)
            ) u_filt (
                .i_clk(I_MCLK),
                .i_rst_n(I_RSTN),
                .i_ce(I_CE),
                .i_raw(sw_raw[g]),
                .o_filt(sw_filt[g])
            );
        end
    endgenerate

    // Mode transitions: entering normal needs every condition; power-up and wake need any one
    always_comb begin
        next_mode = mode;
        unique case (mode)
            CFM_OFF: begin
                if (I_VCC_OK || I_VBAT_OK) next_mode = CFM_STARTUP;
            end
            CFM_STARTUP: begin
                if (!I_VCC_OK && !I_VBAT_OK) next_mode = CFM_OFF;
                else if (su_cnt >= CNT_W'(STARTUP_CYCLES - 1)) begin
                    next_mode = (I_VCC_OK && I_VBAT_OK && standby_select_n && transfer_enable_in)
                        ? CFM_NORMAL : CFM_VBAT_STBY;
                end
            end
            CFM_SLEEP: begin
                if (!I_VBAT_OK) next_mode = CFM_OFF;
                else if (I_CANH_DOM || I_CANL_DOM || I_WAKE_PIN != wake_q) next_mode = CFM_VBAT_STBY;
            end
            default: begin
                if (!I_VCC_OK && !I_VBAT_OK) next_mode = CFM_OFF;
                else if (!I_VCC_OK || !I_VBAT_OK) next_mode = CFM_VBAT_STBY;
                else begin
                    unique case ({standby_select_n, transfer_enable_in})
                        2'b11: next_mode = CFM_NORMAL;
                        2'b10: next_mode = CFM_VCC_STBY;
                        2'b01: next_mode = CFM_GOSLEEP;
                        2'b00: next_mode = (mode == CFM_GOSLEEP) ? CFM_SLEEP : CFM_VBAT_STBY;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            mode <= CFM_OFF;
            mode_q <= CFM_OFF;
            su_cnt <= '0;
        end else if (I_CE) begin
            mode <= next_mode;
            mode_q <= mode;
            su_cnt <= (mode == CFM_STARTUP) ? su_cnt + 1'b1 : '0;
        end
    end

    // Stuck-dominant transmit watchdog; released when transmit goes recessive
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            tx_cnt <= '0;
            tx_timeout <= 1'b0;
        end else if (I_CE) begin
            if (I_TXD) begin
                tx_cnt <= '0;
                tx_timeout <= 1'b0;
            end else if (tx_cnt >= CNT_W'(TXTO_CYCLES - 1)) begin
                tx_timeout <= 1'b1;
            end else begin
                tx_cnt <= tx_cnt + 1'b1;
            end
        end
    end

    // Dominant-only failures held until the next word's start bit
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            txd_q <= 1'b1;
            fail_latched <= 1'b0;
        end else if (I_CE) begin
            txd_q <= I_TXD;
            if (dom_fail) fail_latched <= 1'b1;
            else if (txd_q && !I_TXD) fail_latched <= 1'b0;
        end
    end

    // Wake request held until normal mode selected
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            wake_q <= 1'b0;
            wake_req <= 1'b0;
        end else if (I_CE) begin
            wake_q <= I_WAKE_PIN;
            if (mode == CFM_SLEEP && next_mode != CFM_SLEEP) wake_req <= 1'b1;
            else if (mode == CFM_NORMAL) wake_req <= 1'b0;
        end
    end

    // Pin outputs, all registered
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_RXD <= 1'b1;
            O_BUS_ERROR_INDICATOR_N <= 1'b1;
            O_CANH_DRV_EN <= 1'b0;
            O_CANL_DRV_EN <= 1'b0;
            O_CAN_TX_DOM <= 1'b0;
            O_HIGH_LINE_TERMINATION <= 1'b0;
            O_LOW_LINE_TERMINATION <= 1'b0;
            O_REGULATOR_INHIBIT_OUT <= 1'b0;
        end else if (I_CE) begin
            O_CAN_TX_DOM <= !I_TXD && !tx_timeout && !I_OVERTEMP;
            // Overtemp gates drivers only; receive path untouched
            O_CANH_DRV_EN <= mode == CFM_NORMAL && !sw_filt[0] && !tx_timeout && !I_OVERTEMP;
            O_CANL_DRV_EN <= mode == CFM_NORMAL && !sw_filt[1] && !tx_timeout && !I_OVERTEMP;
            O_HIGH_LINE_TERMINATION <= !sw_filt[0];
            O_LOW_LINE_TERMINATION <= !sw_filt[1];
            O_REGULATOR_INHIBIT_OUT <= !(mode == CFM_SLEEP || mode == CFM_GOSLEEP || mode == CFM_OFF);
            if (mode == CFM_NORMAL) begin
                O_RXD <= !I_DIFF_DOM && !(sw_filt[0] && I_CANL_DOM) && !(sw_filt[1] && I_CANH_DOM);
                O_BUS_ERROR_INDICATOR_N <= !(|sw_filt || fail_latched || tx_timeout);
            end else begin
                O_RXD <= !(wake_req && I_VCC_OK);
                O_BUS_ERROR_INDICATOR_N <= !(wake_req && I_VCC_OK && mode != CFM_VCC_STBY);
            end
        end
    end

    // Register slave: one wait state, waitrequest pulses low once per access
    assign ev = {mode != mode_q, wake_req, I_OVERTEMP, tx_timeout, |sw_filt || dom_fail};
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ack <= 1'b0;
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA <= 32'h0000_0000;
            ctrl <= CTRL_RESET;
            irq_mask <= IRQ_MASK_RESET;
            irq_stat <= '0;
            O_IRQ <= 1'b0;
        end else if (I_CE) begin
            ack <= (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST && !ack;
            O_AVS_WAITREQUEST <= !((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST && !ack);
            if (I_AVS_WRITE && ack && I_AVS_ADDRESS == ADDR_CTRL) ctrl <= I_AVS_WRITEDATA[1:0];
            if (I_AVS_WRITE && ack && I_AVS_ADDRESS == ADDR_IRQ_MASK) irq_mask <= I_AVS_WRITEDATA[EV_W-1:0];
            // Set beats clear so a same-cycle event is never lost
            if (I_AVS_WRITE && ack && I_AVS_ADDRESS == ADDR_IRQ_STAT)
                irq_stat <= (irq_stat & ~I_AVS_WRITEDATA[EV_W-1:0]) | ev;
            else
                irq_stat <= irq_stat | ev;
            O_IRQ <= |(irq_stat & irq_mask);
            if (I_AVS_READ && !ack) begin
                unique case (I_AVS_ADDRESS)
                    ADDR_CTRL: O_AVS_READDATA <= {30'h0, ctrl};
                    ADDR_STATUS: O_AVS_READDATA <= {24'h0, fail_latched, tx_timeout, sw_filt, 1'b0, mode};
                    ADDR_IRQ_STAT: O_AVS_READDATA <= {27'h0, irq_stat};
                    ADDR_IRQ_MASK: O_AVS_READDATA <= {27'h0, irq_mask};
                    default: O_AVS_READDATA <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // cfm_core
`default_nettype wire

// >>> tb/cfm_core_monitor.sv
// Port checker for the CAN bus failure manager core
`timescale 1ns/1ps
`default_nettype none
module cfm_core_monitor #(
    parameter int FILTER_CYCLES = 40,
    parameter int TXTO_CYCLES = 4000
) (
    // Clock and stimulus
    input wire logic I_MCLK,
    input wire logic I_RSTN,
    input wire logic I_CE,
    input wire logic I_TXD,
    input wire logic I_OVERTEMP,
    input wire logic [cfm_pkg::CMP_W-1:0] I_LINE_CMP,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    // Design outputs
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic O_CANH_DRV_EN,
    input wire logic O_CANL_DRV_EN,
    input wire logic O_CAN_TX_DOM,
    input wire logic O_BUS_ERROR_INDICATOR_N,
    input wire logic O_HIGH_LINE_TERMINATION,
    input wire logic O_LOW_LINE_TERMINATION
);
    logic [15:0] dom_run;
    logic [15:0] cmp_run;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RSTN);
    // Saturating, so a long stall cannot wrap back under the limit
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) dom_run <= '0;
        else if (I_TXD) dom_run <= '0;
        else if (I_CE && dom_run != 16'hFFFF) dom_run <= dom_run + 16'h1;
    end
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) cmp_run <= '0;
        else if (I_LINE_CMP == '0) cmp_run <= '0;
        else if (cmp_run != 16'hFFFF) cmp_run <= cmp_run + 16'h1;
    end
    AST_WAIT_ONE: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
        else $error("waitrequest low longer than one cycle");
    AST_ANSWER: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
        else $error("bus request not answered next cycle");
    AST_RDATA: assert property (!(I_AVS_READ && O_AVS_WAITREQUEST) |=> $stable(O_AVS_READDATA))
        else $error("read data moved without a read");
    AST_TXTO_DRV: assert property (dom_run > TXTO_CYCLES + 2 |-> !O_CANH_DRV_EN && !O_CANL_DRV_EN)
        else $error("drivers on after transmit timeout");
    AST_TXTO_ERR: assert property (dom_run > TXTO_CYCLES + 2 |-> !O_BUS_ERROR_INDICATOR_N)
        else $error("transmit timeout not flagged");
    AST_OVT: assert property (I_OVERTEMP ##1 I_OVERTEMP |-> !O_CAN_TX_DOM)
        else $error("transmitter active while hot");
    AST_TX_CAUSE: assert property (O_CAN_TX_DOM |-> !$past(I_TXD))
        else $error("dominant drive without dominant transmit input");
    AST_FILTER: assert property (($fell(O_HIGH_LINE_TERMINATION) && O_LOW_LINE_TERMINATION) ||
        ($fell(O_LOW_LINE_TERMINATION) && O_HIGH_LINE_TERMINATION) |-> cmp_run >= FILTER_CYCLES - 1)
        else $error("line disabled before filter delay");
endmodule // cfm_core_monitor
bind cfm_core cfm_core_monitor #(.FILTER_CYCLES(FILTER_CYCLES), .TXTO_CYCLES(TXTO_CYCLES)) i_mon (
    .I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_CE(I_CE), .I_TXD(I_TXD), .I_OVERTEMP(I_OVERTEMP),
    .I_LINE_CMP(I_LINE_CMP), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
    .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_CANH_DRV_EN(O_CANH_DRV_EN),
    .O_CANL_DRV_EN(O_CANL_DRV_EN), .O_CAN_TX_DOM(O_CAN_TX_DOM), .O_BUS_ERROR_INDICATOR_N(O_BUS_ERROR_INDICATOR_N),
    .O_HIGH_LINE_TERMINATION(O_HIGH_LINE_TERMINATION), .O_LOW_LINE_TERMINATION(O_LOW_LINE_TERMINATION));
`default_nettype wire

// >>> tb/cfm_ctrl_model.sv
// Behavioural protocol controller driving the transmit input
`timescale 1ns/1ps
`default_nettype none
module cfm_ctrl_model (
    // Clock and commands
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_send,
    input wire logic i_stuck,
    // Transmit bit, low is dominant
    output logic o_txd
);
    logic [9:0] word;
    // Word starts dominant, idles recessive
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) word <= '1;
        else if (i_send) word <= 10'h34A;
        else word <= {1'b1, word[9:1]};
    end
    // Stuck models a hung protocol unit
    assign o_txd = i_stuck ? 1'b0 : word[0];
endmodule // cfm_ctrl_model
`default_nettype wire

// >>> tb/can_bus_failure_manager_tb.sv
// Self-checking bench for the CAN bus failure manager core
`timescale 1ns/1ps
`default_nettype none
module can_bus_failure_manager_tb;
    import cfm_pkg::*;
    localparam int FILT = 4;
    localparam int RECOV = 8;
    localparam int TXTO = 16;
    localparam int STUP = 10;
    logic mclk = 0, rstn = 0, vcc_ok = 1, vbat_ok = 1, ovt = 0, diff_dom = 0, canh_dom = 0;
    logic rd = 0, wr = 0, send = 0, stuck = 0, txd, rxd, err_n, h_drv, l_drv, tx_dom, h_term, l_term, wait_rq, irq;
    logic ce = 1, canl_dom = 0, wake_pin = 0, regulator_inhibit_out;
    logic [3:0] cmp = 4'h0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    int fails = 0, num_checks = 0, cyc = 0;
    cfm_core #(.FILTER_CYCLES(FILT), .RECOVER_CYCLES(RECOV), .TXTO_CYCLES(TXTO), .STARTUP_CYCLES(STUP)) i_dut (
        .I_MCLK(mclk), .I_RSTN(rstn), .I_CE(ce), .I_VCC_OK(vcc_ok), .I_VBAT_OK(vbat_ok), .I_OVERTEMP(ovt),
        .I_WAKE_PIN(wake_pin), .I_DIFF_DOM(diff_dom), .I_LINE_CMP(cmp), .I_CANH_DOM(canh_dom), .I_CANL_DOM(canl_dom),
        .I_TXD(txd), .O_RXD(rxd), .O_BUS_ERROR_INDICATOR_N(err_n), .O_CANH_DRV_EN(h_drv), .O_CANL_DRV_EN(l_drv),
        .O_CAN_TX_DOM(tx_dom), .O_HIGH_LINE_TERMINATION(h_term), .O_LOW_LINE_TERMINATION(l_term),
        .O_REGULATOR_INHIBIT_OUT(regulator_inhibit_out), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wait_rq), .O_IRQ(irq));
    cfm_ctrl_model i_ctrl (.i_clk(mclk), .i_rst_n(rstn), .i_send(send), .i_stuck(stuck), .o_txd(txd));
    initial forever #50 mclk = ~mclk;
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Hang guard, well above the sum of all scenario waits
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Holds the request until the edge that samples waitrequest low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (wait_rq !== 1'b0);
        chk(n < 50, 1);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task t_regs;
        bus(0, ADDR_CTRL, 0);
        chk(q, CTRL_RESET);
        bus(0, ADDR_IRQ_MASK, 0);
        chk(q, IRQ_MASK_RESET);
        bus(0, 4'h2, 0);
        chk(q, 0);
        wc(STUP + 4);
        bus(0, ADDR_STATUS, 0);
        chk(q[2:0], CFM_VBAT_STBY);
    endtask
    task t_modes;
        logic [1:0] sel[4];
        cfm_mode_t exp[4];
        sel = '{2'h1, 2'h3, 2'h2, 2'h0};
        exp = '{CFM_VCC_STBY, CFM_NORMAL, CFM_GOSLEEP, CFM_SLEEP};
        for (int i = 0; i < 4; i++) begin
            bus(1, ADDR_CTRL, {30'h0, sel[i]});
            wc(2);
            bus(0, ADDR_STATUS, 0);
            chk(q[2:0], exp[i]);
            wc(50);
        end
    endtask
    // Wake by high line, low line, then wake pin edge
    task t_wake;
        for (int k = 0; k < 3; k++) begin
            if (k > 0) begin
                bus(1, ADDR_CTRL, 32'h2);
                wc(2);
                bus(1, ADDR_CTRL, 32'h0);
                wc(2);
            end
            chk(regulator_inhibit_out, 0);
            canh_dom <= k == 0;
            canl_dom <= k == 1;
            if (k == 2) wake_pin <= 1'b1;
            wc(4);
            canh_dom <= 1'b0;
            canl_dom <= 1'b0;
            wc(STUP + 10);
            bus(0, ADDR_STATUS, 0);
            chk(q[2:0], CFM_VBAT_STBY);
            chk(regulator_inhibit_out, 1);
            chk(rxd, 0);
            chk(err_n, 0);
            bus(1, ADDR_CTRL, 32'h3);
            wc(4);
            chk(rxd, 1);
        end
    endtask
    task t_fail;
        cmp <= 4'h2;
        wc(FILT - 2);
        cmp <= 4'h0;
        wc(4);
        chk(err_n, 1);
        cmp <= 4'h2;
        wc(FILT + 4);
        chk(err_n, 0);
        chk(h_term & l_term, 0);
        chk(h_drv & l_drv, 0);
        chk(h_drv, 1);
        cmp <= 4'h0;
        wc(2);
        bus(0, ADDR_STATUS, 0);
        chk(q[5:4] != 2'h0, 1);
        wc(RECOV + 4);
        bus(0, ADDR_STATUS, 0);
        chk(q[5:4], 0);
        chk(h_term & l_term, 1);
        // Dominant-only pattern: ignored while recessive, held after
        cmp <= 4'h9;
        wc(3);
        chk(err_n, 1);
        diff_dom <= 1'b1;
        wc(3);
        cmp <= 4'h0;
        diff_dom <= 1'b0;
        wc(3);
        chk(err_n, 0);
        bus(0, ADDR_STATUS, 0);
        chk(q[7], 1);
        send <= 1'b1;
        wc(1);
        send <= 1'b0;
        wc(4);
        chk(err_n, 1);
    endtask
    task t_supply;
        vcc_ok <= 1'b0;
        wc(2);
        bus(0, ADDR_STATUS, 0);
        chk(q[2:0], CFM_VBAT_STBY);
        vbat_ok <= 1'b0;
        wc(2);
        bus(0, ADDR_STATUS, 0);
        chk(q[2:0], CFM_OFF);
        chk(regulator_inhibit_out, 0);
        vcc_ok <= 1'b1;
        vbat_ok <= 1'b1;
        wc(2);
        bus(0, ADDR_STATUS, 0);
        chk(q[2:0], CFM_STARTUP);
        wc(STUP + 4);
        bus(0, ADDR_STATUS, 0);
        chk(q[2:0], CFM_NORMAL);
        chk(regulator_inhibit_out, 1);
    endtask
    task t_ovt_irq;
        logic hit;
        bus(1, ADDR_IRQ_STAT, 32'h1F);
        for (int k = 0; k < 2; k++) begin
            ovt <= k[0];
            wc(2);
            send <= 1'b1;
            wc(1);
            send <= 1'b0;
            hit = 1'b0;
            repeat (12) begin
                @(posedge mclk);
                hit = hit | tx_dom;
            end
            chk(hit, k == 0);
        end
        diff_dom <= 1'b1;
        wc(3);
        chk(rxd, 0);
        diff_dom <= 1'b0;
        chk(irq, 0);
        bus(0, ADDR_IRQ_STAT, 0);
        chk(q[EV_OVT], 1);
        bus(1, ADDR_IRQ_MASK, 32'h1 << EV_OVT);
        wc(2);
        chk(irq, 1);
        ovt <= 1'b0;
        wc(2);
        bus(1, ADDR_IRQ_STAT, 32'h1 << EV_OVT);
        wc(2);
        chk(irq, 0);
    endtask
    task t_txto;
        // Frozen enable must hold the watchdog still
        ce <= 1'b0;
        stuck <= 1'b1;
        wc(TXTO + 6);
        chk({h_drv, l_drv}, 2'h3);
        chk(err_n, 1);
        ce <= 1'b1;
        wc(TXTO + 6);
        chk({h_drv, l_drv}, 0);
        chk(err_n, 0);
        bus(0, ADDR_STATUS, 0);
        chk(q[6], 1);
        stuck <= 1'b0;
        wc(4);
    endtask
    initial begin
        wc(20);
        rstn <= 1'b1;
        t_regs();
        t_modes();
        t_wake();
        t_fail();
        t_ovt_irq();
        t_supply();
        t_txto();
        close_out();
    end
endmodule // can_bus_failure_manager_tb
`default_nettype wire
